//--- verilog/handwheel_follow.sv
/*
 handwheel follower: samples a chosen high-speed counter on each tick, scales the
 movement by numerator/denominator and bursts that many pulses on one axis.
 assumes SAMPLE_TICK_I is a one-cycle pulse from a fixed periodic timer, and that
 counter values and axis ownership are synchronous to SYS_CLK_I.
*/
// The implementer's own choices: the AXI4-Lite register port and the address map.
// Functional notes
// R1 - while enabled, each tick reads the selected counter to get input movement
// R2 - a tick with no counter movement produces no output pulses
// R3 - output count is input count times numerator divided by denominator
// R4 - pulses go out at the programmed speed within the same interval
// R5 - counter selector is 0 to 7, axis selector is 0 to 3
// R6 - an axis owned by another positioning function gets no pulses
// R7 - active flag is high exactly while pulses are being emitted
// R8 - four working words hold the engine state, used by nothing else
// R9 - software sets speed and ramps so a high-ratio burst fits one interval
// R10 - the tick must come from a fixed periodic timer
// R11 - remainder is dropped, a zero denominator gives no output
`timescale 1ns/1ps
module handwheel_follow import handwheel_follow_pkg::*; (
	input  wire logic                   SYS_CLK_I,
	input  wire logic                   RESETN_I,
	input  wire logic                   SAMPLE_TICK_I,
	input  wire logic [N_CNT*CNT_W-1:0] COUNTER_VALUE_I,
	input  wire logic [N_AX-1:0]        AXIS_OWNED_I,
	output logic      [N_AX-1:0]        PULSE_O,
	output logic      [N_AX-1:0]        DIR_O,
	output logic                        ACTIVE_O,
	output logic                        IRQ_O,
	input  wire logic [AW-1:0]          AWADDR_I,
	input  wire logic                   AWVALID_I,
	output logic                        AWREADY_O,
	input  wire logic [31:0]            WDATA_I,
	input  wire logic [3:0]             WSTRB_I,
	input  wire logic                   WVALID_I,
	output logic                        WREADY_O,
	output logic      [1:0]             BRESP_O,
	output logic                        BVALID_O,
	input  wire logic                   BREADY_I,
	input  wire logic [AW-1:0]          ARADDR_I,
	input  wire logic                   ARVALID_I,
	output logic                        ARREADY_O,
	output logic      [31:0]            RDATA_O,
	output logic      [1:0]             RRESP_O,
	output logic                        RVALID_O,
	input  wire logic                   RREADY_I
);
	logic [31:0]      ctrl_q;
	logic [31:0]      speed_q;
	logic [31:0]      ratio_q;
	logic [EV_W-1:0]  int_stat_q;
	logic [EV_W-1:0]  int_mask_q;
	logic [CNT_W-1:0] work_q [4];
	follow_state_t    state_q;
	logic [AW-1:0]    awaddr_q;
	logic [31:0]      wdata_q;
	logic [3:0]       wstrb_q;
	logic             aw_held_q;
	logic             w_held_q;
	logic [31:0]      phase_q;
	logic [N_AX-1:0]  pulse_q;
	logic [N_AX-1:0]  dir_q;
	logic             dir_neg_q;
	logic             active_q;
	logic             irq_q;
	logic [ASEL_W-1:0] axis_q;
	logic [DIV_W-1:0] dividend_q;
	logic [RAT_W-1:0] divisor_q;
	logic             start_q;

	logic                enable;
	logic [CSEL_W-1:0]   csel;
	logic [ASEL_W-1:0]   asel;
	logic [RAT_W-1:0]    num;
	logic [RAT_W-1:0]    den;
	logic [CNT_W-1:0]    cur;
	logic [CNT_W-1:0]    delta;
	logic [CNT_W-1:0]    mag;
	logic                sample;
	logic                wr_go;
	logic [31:0]         wmask;
	logic [EV_W-1:0]     ev;
	logic [32:0]         phase_sum;
	logic                step;
	logic                owned;
	logic                rd_hit;
	logic [31:0]         rd_val;

	scale_div_if mc ();

	scale_divider u_div (
		.clk_i    (SYS_CLK_I),
		.resetn_i (RESETN_I),
		.div      (mc.srv)
	);

	assign mc.start = start_q;
	assign mc.dividend = dividend_q;
	assign mc.divisor = divisor_q;

	assign enable = ctrl_q[CTRL_EN];
	assign csel = ctrl_q[CTRL_CSEL +: CSEL_W]; // R5
	assign asel = ctrl_q[CTRL_ASEL +: ASEL_W]; // R5
	assign num = ratio_q[0 +: RAT_W];
	assign den = ratio_q[RATIO_DEN +: RAT_W];
	assign cur = COUNTER_VALUE_I[csel*CNT_W +: CNT_W];
	assign delta = cur - work_q[W_LAST];
	assign mag = delta[CNT_W-1] ? CNT_W'(0) - delta : delta;
	assign sample = SAMPLE_TICK_I && enable; // R10
	assign owned = AXIS_OWNED_I[axis_q];

	assign phase_sum = {1'b0, phase_q} + {1'b0, speed_q};
	assign step = state_q == ST_EMIT && !owned && !pulse_q[axis_q]
		&& phase_sum >= {1'b0, CLK_HZ};

	// events: done, blocked by an owner, divide or burst cut by next tick
	assign ev[EV_DONE] = step && work_q[W_LEFT] == 32'h0000_0001;
	assign ev[EV_BLOCKED] = (state_q == ST_EMIT && owned)
		|| (sample && AXIS_OWNED_I[asel] && delta != '0);
	assign ev[EV_OVERRUN] = sample && state_q != ST_IDLE;

	// sampling, scaling and pulse engine
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_q <= ST_IDLE;
			for (int i = 0; i < 4; i++) begin
				work_q[i] <= '0;
			end
			start_q <= 1'b0;
			dividend_q <= '0;
			divisor_q <= '0;
			axis_q <= '0;
			dir_neg_q <= 1'b0;
			phase_q <= '0;
			pulse_q <= '0;
			dir_q <= '0;
			active_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			pulse_q <= '0;
			if (SAMPLE_TICK_I) begin
				work_q[W_LAST] <= cur;
			end
			if (sample) begin
				work_q[W_DELTA] <= delta; // R1
				axis_q <= asel;
				dir_neg_q <= delta[CNT_W-1];
				dividend_q <= DIV_W'(mag) * DIV_W'(num); // R3
				divisor_q <= den;
				work_q[W_COUNT] <= '0;
				work_q[W_LEFT] <= '0;
				active_q <= 1'b0;
				if (delta == '0 || AXIS_OWNED_I[asel] || den == '0) begin
					state_q <= ST_IDLE; // R2 R6 R11
				end else begin
					state_q <= ST_DIVIDE;
					start_q <= 1'b1;
				end
			end else begin
				case (state_q)
				ST_IDLE: begin
					active_q <= 1'b0;
				end
				ST_DIVIDE: begin
					// a done left over from an abandoned divide lands with the new start
					if (mc.done && !start_q) begin
						// quotient truncated, remainder dropped
						work_q[W_COUNT] <= mc.quotient[CNT_W-1:0]; // R11
						work_q[W_LEFT] <= mc.quotient[CNT_W-1:0];
						phase_q <= '0;
						if (mc.quotient[CNT_W-1:0] != '0 && !owned) begin
							state_q <= ST_EMIT;
							active_q <= 1'b1; // R7
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_EMIT: begin
					dir_q[axis_q] <= dir_neg_q;
					if (owned) begin
						state_q <= ST_IDLE; // R6
						active_q <= 1'b0; // R7
					end else if (step) begin
						phase_q <= 32'(phase_sum - {1'b0, CLK_HZ}); // R4
						pulse_q[axis_q] <= 1'b1;
						work_q[W_LEFT] <= work_q[W_LEFT] - 32'h0000_0001;
						if (work_q[W_LEFT] == 32'h0000_0001) begin
							state_q <= ST_IDLE;
							active_q <= 1'b0; // R7
						end
					end else begin
						phase_q <= 32'(phase_sum);
					end
				end
				default: begin
					state_q <= ST_IDLE;
					active_q <= 1'b0;
				end
				endcase
			end
		end
	end

	assign PULSE_O = pulse_q;
	assign DIR_O = dir_q;
	assign ACTIVE_O = active_q;
	assign IRQ_O = irq_q;

	// AXI4-Lite write path
	assign wr_go = aw_held_q && w_held_q && !BVALID_O;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			AWREADY_O <= 1'b1;
			WREADY_O <= 1'b1;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			BVALID_O <= 1'b0;
			BRESP_O <= RESP_OKAY;
		end else begin
			if (AWVALID_I && AWREADY_O) begin
				awaddr_q <= AWADDR_I;
				aw_held_q <= 1'b1;
				AWREADY_O <= 1'b0;
			end
			if (WVALID_I && WREADY_O) begin
				wdata_q <= WDATA_I;
				wstrb_q <= WSTRB_I;
				w_held_q <= 1'b1;
				WREADY_O <= 1'b0;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				BVALID_O <= 1'b1;
				case (awaddr_q)
				OFS_CTRL, OFS_SPEED, OFS_RATIO, OFS_STATUS, OFS_INT_STAT,
				OFS_INT_MASK: BRESP_O <= RESP_OKAY;
				default: BRESP_O <= RESP_SLVERR;
				endcase
			end
			if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
				AWREADY_O <= 1'b1;
				WREADY_O <= 1'b1;
			end
		end
	end

	// configuration registers
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ctrl_q <= CTRL_RST;
			speed_q <= SPEED_RST;
			ratio_q <= RATIO_RST;
			int_mask_q <= '0;
		end else if (wr_go) begin
			case (awaddr_q)
			OFS_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
			OFS_SPEED: speed_q <= (speed_q & ~wmask) | (wdata_q & wmask);
			OFS_RATIO: ratio_q <= (ratio_q & ~wmask) | (wdata_q & wmask);
			OFS_INT_MASK: int_mask_q <= wdata_q[EV_W-1:0] & wmask[EV_W-1:0];
			default: begin
			end
			endcase
		end
	end

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			int_stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			if (wr_go && awaddr_q == OFS_INT_STAT) begin
				int_stat_q <= (int_stat_q & ~(wdata_q[EV_W-1:0] & wmask[EV_W-1:0])) | ev;
			end else begin
				int_stat_q <= int_stat_q | ev;
			end
			irq_q <= |(int_stat_q & int_mask_q);
		end
	end

	// AXI4-Lite read path
	always_comb begin
		rd_hit = 1'b1;
		rd_val = '0;
		case (ARADDR_I)
		OFS_CTRL: rd_val = ctrl_q;
		OFS_SPEED: rd_val = speed_q;
		OFS_RATIO: rd_val = ratio_q;
		OFS_STATUS: rd_val = {29'h0, state_q == ST_DIVIDE, owned, active_q};
		OFS_INT_STAT: rd_val = {29'h0, int_stat_q};
		OFS_INT_MASK: rd_val = {29'h0, int_mask_q};
		default: begin
			if (ARADDR_I >= OFS_WORK0 && ARADDR_I <= OFS_WORK3 && ARADDR_I[1:0] == 2'h0) begin
				rd_val = work_q[ARADDR_I[3:2]]; // R8
			end else begin
				rd_hit = 1'b0;
			end
		end
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ARREADY_O <= 1'b1;
			RVALID_O <= 1'b0;
			RDATA_O <= '0;
			RRESP_O <= RESP_OKAY;
		end else begin
			if (ARVALID_I && ARREADY_O) begin
				ARREADY_O <= 1'b0;
				RVALID_O <= 1'b1;
				RDATA_O <= rd_val;
				RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (RVALID_O && RREADY_I) begin
				RVALID_O <= 1'b0;
				ARREADY_O <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);

	a_sample_reads: assert property (sample |=> work_q[W_DELTA] == $past(delta)) // R1
		else $error("sampled movement not stored");
	a_zero_quiet: assert property (sample && delta == '0 |=> state_q == ST_IDLE [*2]) // R2
		else $error("burst started without movement");
	a_scale_ratio: assert property (mc.done && state_q == ST_DIVIDE && !start_q // R3
		|-> mc.quotient == dividend_q / DIV_W'(divisor_q))
		else $error("scaled count wrong");
	a_emit_count: assert property (step && !sample |=> work_q[W_LEFT] == $past(work_q[W_LEFT]) - 1) // R4
		else $error("pulse not counted");
	a_axis_only: assert property ((PULSE_O & ~(N_AX'(1) << axis_q)) == '0) // R5
		else $error("pulse on unselected axis");
	a_owned_quiet: assert property (state_q == ST_EMIT && owned |=> !active_q && pulse_q == '0) // R6
		else $error("pulses on owned axis");
	a_active_flag: assert property (ACTIVE_O == (state_q == ST_EMIT)) // R7
		else $error("active flag out of step");
	a_work_hold: assert property (state_q == ST_IDLE && !SAMPLE_TICK_I |=> $stable(work_q[W_LEFT])) // R8
		else $error("working word changed while idle");
	a_zero_divisor: assert property (sample && den == '0 |=> state_q == ST_IDLE) // R11
		else $error("zero denominator started a burst");
	a_irq_level: assert property (##1 IRQ_O == |($past(int_stat_q) & $past(int_mask_q)))
		else $error("interrupt level wrong");

	c_burst_done: cover property (ev[EV_DONE]);
	c_blocked: cover property (ev[EV_BLOCKED]);
	c_overrun: cover property (ev[EV_OVERRUN]);
	c_reverse: cover property (step && dir_neg_q);
endmodule

//--- verilog/handwheel_follow_pkg.sv
/*
 package for the handwheel follower: register map, field positions, reset values, states.
 assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package handwheel_follow_pkg;
	localparam int CNT_W = 32;
	localparam int DIV_W = 48;
	localparam int RAT_W = 16;
	localparam int N_CNT = 8;
	localparam int N_AX  = 4;
	localparam int CSEL_W = 3;
	localparam int ASEL_W = 2;
	localparam int EV_W  = 3;
	localparam int AW    = 8;
	localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
	localparam logic [AW-1:0] OFS_SPEED    = 8'h04;
	localparam logic [AW-1:0] OFS_RATIO    = 8'h08;
	localparam logic [AW-1:0] OFS_STATUS   = 8'h0C;
	localparam logic [AW-1:0] OFS_INT_STAT = 8'h10;
	localparam logic [AW-1:0] OFS_INT_MASK = 8'h14;
	localparam logic [AW-1:0] OFS_WORK0    = 8'h20;
	localparam logic [AW-1:0] OFS_WORK3    = 8'h2C;
	localparam int CTRL_EN   = 0;
	localparam int CTRL_CSEL = 4;
	localparam int CTRL_ASEL = 8;
	localparam int RATIO_DEN = 16;
	localparam int EV_DONE    = 0;
	localparam int EV_BLOCKED = 1;
	localparam int EV_OVERRUN = 2;
	localparam int W_LAST = 0;
	localparam int W_DELTA = 1;
	localparam int W_COUNT = 2;
	localparam int W_LEFT = 3;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] SPEED_RST = 32'h0003_0D40;
	localparam logic [31:0] RATIO_RST = 32'h0001_0001;
	localparam logic [31:0] CLK_HZ    = 32'h017D_7840;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_EMIT} follow_state_t;
endpackage

//--- verilog/scale_div_if.sv
/*
 interface between the follower engine and its divider.
 assumes the engine holds dividend and divisor stable while the divider runs.
*/
`timescale 1ns/1ps
interface scale_div_if import handwheel_follow_pkg::*; ();
	logic             start;
	logic [DIV_W-1:0] dividend;
	logic [RAT_W-1:0] divisor;
	logic             done;
	logic [DIV_W-1:0] quotient;
	modport req (output start, dividend, divisor, input done, quotient);
	modport srv (input start, dividend, divisor, output done, quotient);
endinterface

//--- verilog/scale_divider.sv
/*
 sequential restoring divider, one quotient bit per clock.
 assumes a nonzero divisor; done pulses DIV_W+1 cycles after start.
*/
`timescale 1ns/1ps
module scale_divider import handwheel_follow_pkg::*; (
	input  wire logic   clk_i,
	input  wire logic   resetn_i,
	scale_div_if.srv    div
);
	logic [RAT_W:0]   rem_q;
	logic [DIV_W-1:0] quo_q;
	logic [7:0]       cnt_q;
	logic             done_q;
	logic [RAT_W:0]   shifted;
	logic             fits;

	assign shifted = {rem_q[RAT_W-1:0], quo_q[DIV_W-1]};
	assign fits = shifted >= {1'b0, div.divisor};
	assign div.done = done_q;
	assign div.quotient = quo_q;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rem_q <= '0;
			quo_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (div.start) begin
				rem_q <= '0;
				quo_q <= div.dividend;
				cnt_q <= 8'(DIV_W);
			end else if (cnt_q != '0) begin
				rem_q <= fits ? shifted - {1'b0, div.divisor} : shifted;
				quo_q <= {quo_q[DIV_W-2:0], fits};
				cnt_q <= cnt_q - 8'h01;
				done_q <= cnt_q == 8'h01;
			end
		end
	end
endmodule

//--- tb/handwheel_partner.sv
/*
 far-side model: handwheel encoder counters feeding the follower, and pulse
 drives that count the steps they receive.
 assumes the bench moves one counter at a time and steps are one-cycle pulses.
*/
`timescale 1ns/1ps
module handwheel_partner import handwheel_follow_pkg::*; (
	input  wire logic                   clk_i,
	input  wire logic                   go_i,
	input  wire logic [CSEL_W-1:0]      sel_i,
	input  wire logic [CNT_W-1:0]       move_i,
	input  wire logic                   clr_i,
	input  wire logic [N_AX-1:0]        pulse_i,
	output logic      [N_CNT*CNT_W-1:0] count_o,
	output logic      [N_AX*16-1:0]     steps_o
);
	initial begin
		count_o = '0;
		steps_o = '0;
	end
	// encoder turns: counter moves by the commanded amount
	always @(posedge clk_i) begin
		if (go_i)
			count_o[sel_i*CNT_W +: CNT_W] <= count_o[sel_i*CNT_W +: CNT_W] + move_i;
		for (int a = 0; a < N_AX; a++) begin
			if (clr_i)
				steps_o[a*16 +: 16] <= 16'h0000;
			else if (pulse_i[a])
				steps_o[a*16 +: 16] <= steps_o[a*16 +: 16] + 16'h0001;
		end
	end
endmodule

//--- tb/tb_top.sv
/*
 bench for the handwheel follower: register access over the register bus,
 periodic sampling ticks, bursts checked against the scaled count.
 assumes the follower and the partner model share one 25 MHz clock.
*/
`timescale 1ns/1ps
module tb_top import handwheel_follow_pkg::*;;
	localparam int IV = 1000;
	logic clk = 1'h0, rstn = 1'h0, tick = 1'h0, go = 1'h0, clr = 1'h0, seen;
	logic [CSEL_W-1:0]      sel = '0;
	logic [CNT_W-1:0]       mv = '0;
	logic [N_AX-1:0]        owned = '0, pulse, dir;
	logic [N_CNT*CNT_W-1:0] cnt;
	logic [N_AX*16-1:0]     steps;
	logic                   active, irq, awready, wready, bvalid, arready, rvalid;
	logic [AW-1:0]          awaddr = '0, araddr = '0;
	logic                   awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic                   arvalid = 1'h0, rready = 1'h0;
	logic [31:0]            wdata = '0, rdata, rd;
	logic [3:0]             wstrb = '0;
	logic [1:0]             bresp, rresp, rs;
	int                     fail_count = 0, total_checks = 0;

	always #20 clk = ~clk;

	handwheel_follow handwheel_follow_inst (.SYS_CLK_I(clk), .RESETN_I(rstn),
		.SAMPLE_TICK_I(tick), .COUNTER_VALUE_I(cnt), .AXIS_OWNED_I(owned), .PULSE_O(pulse),
		.DIR_O(dir), .ACTIVE_O(active), .IRQ_O(irq), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));

	handwheel_partner handwheel_partner_inst (.clk_i(clk), .go_i(go), .sel_i(sel),
		.move_i(mv), .clr_i(clr), .pulse_i(pulse), .count_o(cnt), .steps_o(steps));

	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid)
				break;
		end
		if (n == 50) begin
			fail_count++;
			print_verdict;
		end
		r = bresp;
		bready <= 1'h0;
	endtask

	task rdr(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid)
				break;
		end
		if (n == 50) begin
			fail_count++;
			print_verdict;
		end
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	// one tick, then a whole fixed interval of watching
	task tick_wait;
		@(posedge clk);
		tick <= 1'h1;
		@(posedge clk);
		tick <= 1'h0;
		seen = 1'h0;
		repeat (IV) begin
			@(posedge clk);
			if (active === 1'h1)
				seen = 1'h1;
		end
	endtask

	task burst(input int cs, input int as, input logic [15:0] num, input logic [15:0] den,
			input logic [31:0] m, input logic own, input logic [15:0] n_exp, input logic msk);
		logic [31:0] c;
		c = 32'(cs << CTRL_CSEL) | 32'(as << CTRL_ASEL);
		wr(OFS_CTRL, c, rs);
		wr(OFS_RATIO, {den, num}, rs);
		wr(OFS_INT_MASK, {31'h0000_0000, msk}, rs);
		wr(OFS_INT_STAT, 32'h0000_0007, rs);
		// baseline settles while disabled
		tick_wait;
		@(posedge clk);
		go <= 1'h1;
		sel <= cs[CSEL_W-1:0];
		mv <= m;
		clr <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		clr <= 1'h0;
		owned <= N_AX'(own) << as;
		wr(OFS_CTRL, c | 32'h0000_0001, rs);
		chk(steps, 64'h0000_0000_0000_0000);
		tick_wait;
		chk(steps, 64'(n_exp) << (as * 16));
		chk(64'(seen), 64'(n_exp != 16'h0000));
		chk(64'(active), 64'h0000_0000_0000_0000);
		chk(64'(irq), 64'(msk && n_exp != 16'h0000));
		rdr(OFS_INT_STAT, rd, rs);
		chk(64'(rd[EV_DONE]), 64'(n_exp != 16'h0000));
		chk(64'(rd[EV_BLOCKED]), 64'(own));
		rdr(OFS_STATUS, rd, rs);
		chk(64'(rd), 64'(own) << 1);
		if (n_exp != 16'h0000) begin
			chk(64'(dir[as]), 64'(m[31]));
			rdr(OFS_WORK0 + 8'h08, rd, rs);
			chk(64'(rd), 64'(n_exp));
		end
		wr(OFS_INT_STAT, 32'h0000_0001, rs);
		owned <= '0;
		repeat (2) @(posedge clk);
		chk(64'(irq), 64'h0000_0000_0000_0000);
		$display("test burst on axis %0d done", as);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'h1;
		rdr(OFS_CTRL, rd, rs);
		chk(64'(rd), 64'(CTRL_RST));
		rdr(OFS_SPEED, rd, rs);
		chk(64'(rd), 64'(SPEED_RST));
		rdr(OFS_RATIO, rd, rs);
		chk(64'(rd), 64'(RATIO_RST));
		rdr(OFS_INT_MASK, rd, rs);
		chk(64'(rd), 64'h0000_0000_0000_0000);
		rdr(8'h40, rd, rs);
		chk(64'({rs, rd}), 64'({RESP_SLVERR, 32'h0000_0000}));
		wr(8'h40, 32'h0000_0001, rs);
		chk(64'(rs), 64'(RESP_SLVERR));
		wr(OFS_WORK3, 32'h0000_1234, rs);
		rdr(OFS_WORK3, rd, rs);
		chk(64'(rd), 64'h0000_0000_0000_0000);
		$display("test registers done");
		wr(OFS_SPEED, 32'h00BE_BC20, rs);
		burst(3, 2, 16'h0003, 16'h0002, 32'h0000_0005, 1'h0, 16'h0007, 1'h1);
		burst(0, 0, 16'h0001, 16'h0001, 32'h0000_0000, 1'h0, 16'h0000, 1'h1);
		burst(7, 3, 16'h00C8, 16'h0001, 32'hFFFF_FFFE, 1'h0, 16'h0190, 1'h1);
		burst(5, 1, 16'h0001, 16'h0001, 32'h0000_0004, 1'h1, 16'h0000, 1'h1);
		burst(1, 1, 16'h0004, 16'h0000, 32'h0000_0003, 1'h0, 16'h0000, 1'h1);
		burst(2, 0, 16'h0001, 16'h0001, 32'h0000_0006, 1'h0, 16'h0006, 1'h0);
		// a tick inside the divide abandons it, no pulses follow
		wr(OFS_CTRL, 32'h0000_0040, rs);
		wr(OFS_INT_STAT, 32'h0000_0007, rs);
		tick_wait;
		@(posedge clk);
		go <= 1'h1;
		sel <= 3'h4;
		mv <= 32'h0000_0064;
		clr <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		clr <= 1'h0;
		wr(OFS_CTRL, 32'h0000_0041, rs);
		repeat (2) begin
			@(posedge clk);
			tick <= 1'h1;
			@(posedge clk);
			tick <= 1'h0;
			repeat (10) @(posedge clk);
		end
		repeat (IV) @(posedge clk);
		chk(steps, 64'h0000_0000_0000_0000);
		rdr(OFS_INT_STAT, rd, rs);
		chk(64'(rd), 64'h0000_0000_0000_0004);
		$display("test overrun done");
		// axis taken over mid-burst: burst cut, rest left over
		wr(OFS_INT_STAT, 32'h0000_0007, rs);
		@(posedge clk);
		go <= 1'h1;
		mv <= 32'h0000_0064;
		@(posedge clk);
		go <= 1'h0;
		@(posedge clk);
		tick <= 1'h1;
		@(posedge clk);
		tick <= 1'h0;
		repeat (100) @(posedge clk);
		owned <= 4'h1;
		repeat (4) @(posedge clk);
		chk(64'(active), 64'h0000_0000_0000_0000);
		chk(steps, 64'h0000_0000_0000_0019);
		rdr(OFS_WORK3, rd, rs);
		chk(64'(rd), 64'h0000_0000_0000_004B);
		rdr(OFS_INT_STAT, rd, rs);
		chk(64'(rd), 64'h0000_0000_0000_0002);
		owned <= '0;
		$display("test takeover done");
		print_verdict;
	end
endmodule
